/* hdl/mss_select.sv */
// Purpose: Chooses the active configuration memory from two switch inputs.
// Assumes: Synchronous active-low reset, switches from outside the domain.
// Notes: Memory changes run through a fade, indicator and fade-in sequence.
//
// Contract
// - Up to six memories, A always valid.
// - Per input pull polarity; one is_static bit sets momentary/static for both inputs.
// - Switch kind plus jump flag give modes.
// - Momentary: start A, press loads next valid.
// - Press at last valid memory wraps to A.
// - Momentary jump, input two open: skip D.
// - Momentary jump: input two high selects D.
// - Input two high: presses ignored entirely.
// - Input two opens: restore previous memory.
// - Static: A, B, C, D binary mapping.
// - Static invalid selection loads memory A; static jump mode loads D even when D is invalid.
// - Static modes follow inputs continuously.
// - Static: start in currently selected memory; the code starts in A and fades to it once start-up ends.
// - Static jump: A, B-or-A, else D.
// - Static jump: input one ignored while two high.
// - Leaving D delayed 1.5/3.5/5.5 s or off.
// - Change: fade out, indicator, switch, fade in.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module mss_select
  import mss_pkg::*;
#(
  parameter int DEB_CYCLES = DEB_CYC,
  parameter int HOLD1_CYCLES = HOLD1_CYC,
  parameter int HOLD2_CYCLES = HOLD2_CYC,
  parameter int HOLD3_CYCLES = HOLD3_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic first_select_input,
  input wire logic second_select_input,
  output logic [2:0] mem_sel,
  output logic fade_active,
  output logic indicator_play
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [2:0] next_valid(input logic [2:0] cur,
                                            input logic [5:0] vld,
                                            input logic skipd);
    logic [2:0] res;
    logic [2:0] idx;
    logic hit;
    res = MEM_A;
    hit = 1'b0;
    idx = cur;
    for (int i = 0; i < 5; i++) begin
      idx = (idx == MEM_LAST) ? MEM_A : idx + 3'h1;
      if (!hit && idx == MEM_A) begin
        hit = 1'b1;
      end else if (!hit && vld[idx] && !(skipd && idx == MEM_D)) begin
        res = idx;
        hit = 1'b1;
      end
    end
    return res;
  endfunction

  function automatic logic [2:0] fallback(input logic [2:0] idx,
                                          input logic [5:0] vld);
    return vld[idx] ? idx : MEM_A;
  endfunction

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  mss_ctrl_s ctrl_r, ctrl_nxt;
  logic [5:0] vld_r, vld_nxt;
  logic [7:0] awa_r, awa_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wstb_r, wstb_nxt;
  logic [2:0] sel_r, mem_r;
  mss_sw_s act_r;
  mss_fade_e st_r;

  assign awready = !aw_have_r;
  assign wready = !w_have_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  always_comb begin
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    wstb_nxt = wstb_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    bvalid_nxt = bvalid_r && !bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    ctrl_nxt = ctrl_r;
    vld_nxt = vld_r;
    if (awvalid && awready) begin
      awa_nxt = awaddr;
      aw_have_nxt = 1'b1;
    end
    if (wvalid && wready) begin
      wd_nxt = wdata[7:0];
      wstb_nxt = wstrb[0];
      w_have_nxt = 1'b1;
    end
    if (aw_have_r && w_have_r && !bvalid_r) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (awa_r == ADDR_CTRL) begin
        if (wstb_r) begin
          ctrl_nxt = mss_ctrl_s'(wd_r[6:0]);
        end
      end else if (awa_r == ADDR_VALID) begin
        if (wstb_r) begin
          vld_nxt = wd_r[5:0] | VALID_RST;
        end
      end else if (awa_r != ADDR_STATUS) begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      case (araddr)
        ADDR_CTRL: rdata_nxt[6:0] = ctrl_r;
        ADDR_VALID: rdata_nxt[5:0] = vld_r;
        ADDR_STATUS: rdata_nxt[9:0] = {(st_r != ST_IDLE), act_r, sel_r,
                                        1'b0, mem_r};
        default: rresp_nxt = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= mss_ctrl_s'(CTRL_RST[6:0]);
      vld_r <= VALID_RST;
      awa_r <= 8'h00;
      wd_r <= 8'h00;
      wstb_r <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      vld_r <= vld_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      wstb_r <= wstb_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Switch conditioning
  // ----------------------------------------------------------------------
  logic [2:0] sy1_r, sy2_r, sy1_nxt, sy2_nxt;
  logic [23:0] dc1_r, dc2_r, dc1_nxt, dc2_nxt;
  mss_sw_s act_nxt;
  logic press;

  always_comb begin
    sy1_nxt = {sy1_r[1:0], first_select_input ^ ctrl_r.pullup1};
    sy2_nxt = {sy2_r[1:0], second_select_input ^ ctrl_r.pullup2};
    act_nxt = act_r;
    dc1_nxt = 24'h00_0000;
    dc2_nxt = 24'h00_0000;
    if (sy1_r[1] == sy1_r[2] && sy1_r[2] != act_r.in1) begin
      dc1_nxt = dc1_r + 24'h00_0001;
      if (dc1_r == 24'(DEB_CYCLES - 1)) begin
        act_nxt.in1 = sy1_r[2];
        dc1_nxt = 24'h00_0000;
      end
    end
    if (sy2_r[1] == sy2_r[2] && sy2_r[2] != act_r.in2) begin
      dc2_nxt = dc2_r + 24'h00_0001;
      if (dc2_r == 24'(DEB_CYCLES - 1)) begin
        act_nxt.in2 = sy2_r[2];
        dc2_nxt = 24'h00_0000;
      end
    end
  end

  assign press = act_nxt.in1 && !act_r.in1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_r <= 3'h0;
      sy2_r <= 3'h0;
      dc1_r <= 24'h00_0000;
      dc2_r <= 24'h00_0000;
      act_r <= 2'h0;
    end else begin
      sy1_r <= sy1_nxt;
      sy2_r <= sy2_nxt;
      dc1_r <= dc1_nxt;
      dc2_r <= dc2_nxt;
      act_r <= act_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Selection and fader
  // ----------------------------------------------------------------------
  logic [2:0] sel_nxt, mem_nxt, held_r, held_nxt;
  logic [27:0] hold_r, hold_nxt;
  logic [11:0] fc_r, fc_nxt;
  logic [23:0] init_r, init_nxt;
  logic in_init, jumped, fade_r, ind_r;
  mss_fade_e st_nxt;

  assign in_init = init_r != 24'h00_0000;
  assign jumped = act_r.in2 || hold_r != 28'h000_0000;

  always_comb begin
    sel_nxt = sel_r;
    held_nxt = held_r;
    hold_nxt = hold_r;
    init_nxt = in_init ? init_r - 24'h00_0001 : init_r;
    if (ctrl_r.jump_en && !act_nxt.in2 && act_r.in2) begin
      case (ctrl_r.hold_sel)
        2'h1: hold_nxt = 28'(HOLD1_CYCLES);
        2'h2: hold_nxt = 28'(HOLD2_CYCLES);
        2'h3: hold_nxt = 28'(HOLD3_CYCLES);
        default: hold_nxt = 28'h000_0000;
      endcase
    end else if (act_r.in2 || !ctrl_r.jump_en) begin
      hold_nxt = 28'h000_0000;
    end else if (hold_r != 28'h000_0000) begin
      hold_nxt = hold_r - 28'h000_0001;
    end
    if (ctrl_r.is_static) begin
      if (!ctrl_r.jump_en) begin
        sel_nxt = fallback({1'b0, act_r.in2, act_r.in1}, vld_r);
      end else if (jumped) begin
        sel_nxt = MEM_D;
      end else begin
        sel_nxt = act_r.in1 ? fallback(MEM_B, vld_r) : MEM_A;
      end
    end else if (ctrl_r.jump_en) begin
      if (act_r.in2 && sel_r != MEM_D) begin
        held_nxt = sel_r;
        sel_nxt = MEM_D;
      end else if (act_r.in2) begin
        sel_nxt = MEM_D;
      end else if (hold_r == 28'h000_0001 ||
                   (sel_r == MEM_D && hold_r == 28'h000_0000)) begin
        sel_nxt = held_r;
      end else if (press && !in_init && hold_r == 28'h000_0000) begin
        sel_nxt = next_valid(sel_r, vld_r, 1'b1);
      end
    end else if (press && !in_init) begin
      sel_nxt = next_valid(sel_r, vld_r, 1'b0);
    end
  end

  always_comb begin
    st_nxt = st_r;
    fc_nxt = (fc_r != 12'h000) ? fc_r - 12'h001 : fc_r;
    mem_nxt = mem_r;
    case (st_r)
      ST_IDLE: begin
        if (init_r > 24'h00_0001) begin
          mem_nxt = sel_nxt;
        end else if (sel_r != mem_r) begin
          st_nxt = ST_FADE_OUT;
          fc_nxt = 12'(FADE_CYC - 1);
        end
      end
      ST_FADE_OUT: begin
        if (fc_r == 12'h000) begin
          st_nxt = ctrl_r.ind_en ? ST_IND : ST_SWITCH;
          fc_nxt = 12'(IND_CYC - 1);
        end
      end
      ST_IND: begin
        if (fc_r == 12'h000) begin
          st_nxt = ST_SWITCH;
        end
      end
      ST_SWITCH: begin
        mem_nxt = sel_r;
        st_nxt = ST_FADE_IN;
        fc_nxt = 12'(FADE_CYC - 1);
      end
      ST_FADE_IN: begin
        if (fc_r == 12'h000) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r <= MEM_A;
      mem_r <= MEM_A;
      held_r <= MEM_A;
      hold_r <= 28'h000_0000;
      fc_r <= 12'h000;
      init_r <= 24'(DEB_CYCLES + 4);
      st_r <= ST_IDLE;
      fade_r <= 1'b0;
      ind_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      mem_r <= mem_nxt;
      held_r <= held_nxt;
      hold_r <= hold_nxt;
      fc_r <= fc_nxt;
      init_r <= init_nxt;
      st_r <= st_nxt;
      fade_r <= st_nxt != ST_IDLE;
      ind_r <= st_nxt == ST_IND;
    end
  end

  assign mem_sel = mem_r;
  assign fade_active = fade_r;
  assign indicator_play = ind_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_range;
    mem_r <= MEM_LAST && vld_r[0];
  endproperty
  a_range: assert property (p_range) else $error("memory out of range");

  property p_wrap;
    press && !in_init && !ctrl_r.is_static && !ctrl_r.jump_en &&
      sel_r == MEM_LAST |=> sel_r == MEM_A;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to A");

  property p_skipd;
    press && !in_init && !ctrl_r.is_static && ctrl_r.jump_en && !jumped
      |=> sel_r != MEM_D;
  endproperty
  a_skipd: assert property (p_skipd) else $error("D not skipped");

  property p_jump;
    !ctrl_r.is_static && ctrl_r.jump_en && act_r.in2 |=> sel_r == MEM_D;
  endproperty
  a_jump: assert property (p_jump) else $error("no jump to D");

  property p_restore;
    !ctrl_r.is_static && ctrl_r.jump_en && ctrl_r.hold_sel == 2'h0 &&
      $fell(act_r.in2) |=> sel_r == $past(held_r);
  endproperty
  a_restore: assert property (p_restore) else $error("no restore");

  property p_static;
    ctrl_r.is_static && !ctrl_r.jump_en && act_r.in1 && act_r.in2
      |=> sel_r == (vld_r[3] ? MEM_D : MEM_A);
  endproperty
  a_static: assert property (p_static) else $error("bad static map");

  property p_hold;
    ctrl_r.jump_en && hold_r > 28'h000_0001 |=> sel_r == MEM_D;
  endproperty
  a_hold: assert property (p_hold) else $error("left D early");

  property p_fade;
    !in_init && $changed(mem_r) |-> fade_r ##1 fade_r;
  endproperty
  a_fade: assert property (p_fade) else $error("switch without fade");

  property p_press;
    press |=> !press;
  endproperty
  a_press: assert property (p_press) else $error("press repeated");

endmodule

/* shared/mss_pkg.sv */
// Purpose: Shared constants and types for the memory select switch logic.
// Assumes: 40 MHz system clock, AXI4-Lite register access.
// Notes: Times are kept in their own unit; cycle counts derive from them.
package mss_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ = 40000;
  localparam int DEB_MS = 10;
  localparam int DEB_CYC = DEB_MS * CLK_KHZ;
  localparam int HOLD1_MS = 1500;
  localparam int HOLD2_MS = 3500;
  localparam int HOLD3_MS = 5500;
  localparam int HOLD1_CYC = HOLD1_MS * CLK_KHZ;
  localparam int HOLD2_CYC = HOLD2_MS * CLK_KHZ;
  localparam int HOLD3_CYC = HOLD3_MS * CLK_KHZ;
  localparam int FADE_US = 20;
  localparam int FADE_CYC = FADE_US * CLK_KHZ / 1000;
  localparam int IND_US = 50;
  localparam int IND_CYC = IND_US * CLK_KHZ / 1000;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_VALID = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] VALID_RST = 6'h01;
  localparam logic [2:0] MEM_A = 3'h0;
  localparam logic [2:0] MEM_B = 3'h1;
  localparam logic [2:0] MEM_D = 3'h3;
  localparam logic [2:0] MEM_LAST = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register fields, bit 6 downward.
  typedef struct packed {
    logic ind_en;
    logic [1:0] hold_sel;
    logic pullup2;
    logic pullup1;
    logic jump_en;
    logic is_static;
  } mss_ctrl_s;

  // Conditioned switch levels, true when the switch is closed.
  typedef struct packed {
    logic in2;
    logic in1;
  } mss_sw_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FADE_OUT,
    ST_IND,
    ST_SWITCH,
    ST_FADE_IN
  } mss_fade_e;

endpackage

/* test/mss_switch_model.sv */
// Purpose: Two mechanical user switches with contact bounce.
// Assumes: A closed switch ties the pin to the rail opposite its pull.
// Notes: Each change of a switch chatters for three cycles.
`timescale 1ns/1ps
module mss_switch_model (
  input wire logic aclk,
  input wire logic [1:0] closed,
  input wire logic [1:0] pull_up,
  output logic [1:0] pin
);
  // ----------
  // Level and bounce
  // ----------
  logic [1:0] lvl;
  logic [1:0] last_r = 2'h0;
  logic [1:0] chg_r = 2'h0;
  logic [1:0] cnt_r = 2'h0;
  assign lvl = closed ^ pull_up;
  always @(posedge aclk) begin
    if (lvl != last_r) begin
      cnt_r <= 2'h3;
      chg_r <= lvl ^ last_r;
    end else if (cnt_r != 2'h0) begin
      cnt_r <= cnt_r - 2'h1;
    end
    last_r <= lvl;
  end
  // Only the switch that moved chatters.
  assign pin = (cnt_r != 2'h0) ? (lvl ^ (chg_r & {2{cnt_r[0]}})) : lvl;
endmodule

/* test/mss_select_tb_top.sv */
// Purpose: Self-checking bench for the memory select switch logic.
// Assumes: Short debounce and hold counts; 40 MHz clock.
// Notes: Switch pins come from the bouncing switch model.
`timescale 1ns/1ps
module mss_select_tb_top
  import mss_pkg::*;
;
  // ----------
  // Signals and instances
  // ----------
  localparam int DEB = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [1:0] closed = 2'h0;
  logic [1:0] pull_up = 2'h0;
  logic [1:0] pin;
  logic [2:0] mem_sel;
  logic fade_active;
  logic indicator_play;
  logic fade_q = 1'b0;
  int num_errors = 0;
  int n_checks = 0;
  int nfade = 0;
  logic [31:0] seed = 32'hf05a_a219;

  always #12.5 aclk = ~aclk;

  always @(posedge aclk) begin
    fade_q <= fade_active;
    if (fade_active === 1'b1 && fade_q === 1'b0) nfade <= nfade + 1;
  end

  mss_select #(.DEB_CYCLES(DEB), .HOLD1_CYCLES(20), .HOLD2_CYCLES(40),
    .HOLD3_CYCLES(60)) mss_select_i (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .first_select_input(pin[0]),
    .second_select_input(pin[1]), .mem_sel(mem_sel),
    .fade_active(fade_active), .indicator_play(indicator_play));

  mss_switch_model mss_switch_model_i (.aclk(aclk), .closed(closed),
    .pull_up(pull_up), .pin(pin));

  // ----------
  // Tasks and functions
  // ----------
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      num_errors++;
      $display("Wait limit used up at %0t", $time);
      tally_and_finish();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int k;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if ((!awvalid || awready) && (!wvalid || wready)) break;
    end
    tmo(k, 50);
    bready <= 1'b1;
    for (k = 0; k < 50 && bvalid !== 1'b1; k++) @(posedge aclk);
    tmo(k, 50);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready) break;
    end
    tmo(k, 50);
    arvalid <= 1'b0;
    rready <= 1'b1;
    for (k = 0; k < 50 && rvalid !== 1'b1; k++) @(posedge aclk);
    tmo(k, 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Lets a pending memory change run to its end.
  task automatic sett();
    int k;
    for (k = 0; k < 60 && fade_active !== 1'b1; k++) @(posedge aclk);
    for (k = 0; k < 6000 && fade_active !== 1'b0; k++) @(posedge aclk);
    tmo(k, 6000);
    @(posedge aclk);
  endtask

  task automatic sw(input logic [1:0] c);
    closed <= c;
    repeat (30) @(posedge aclk);
    sett();
  endtask

  task automatic press();
    sw(closed | 2'h1);
    sw(closed & 2'h2);
  endtask

  task automatic rst();
    aresetn <= 1'b0;
    closed <= 2'h0;
    pull_up <= 2'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (DEB + 6) @(posedge aclk);
  endtask

  task automatic cfg(input logic [7:0] c, input logic [5:0] v);
    logic [1:0] r;
    axw(ADDR_VALID, 32'(v), r);
    axw(ADDR_CTRL, 32'(c), r);
    pull_up <= c[3:2];
    sett();
    sett();
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [2:0] nxt(input logic [2:0] c,
                                     input logic [5:0] v, input logic s);
    logic [2:0] m;
    for (int i = 1; i < 7; i++) begin
      m = 3'((int'(c) + i) % 6);
      if (v[m] && !(s && m == MEM_D)) return m;
    end
    return MEM_A;
  endfunction

  function automatic logic [2:0] smap(input logic [1:0] c,
                                      input logic [5:0] v);
    return v[c] ? {1'b0, c} : MEM_A;
  endfunction

  // ----------
  // Main sequence
  // ----------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [2:0] e;
    logic [5:0] v;
    int k;
    rst();
    axr(ADDR_CTRL, d, r);
    chk(d, 32'h0000_0000);
    axr(ADDR_VALID, d, r);
    chk(d, 32'h0000_0001);
    axw(ADDR_VALID, 32'h0000_0000, r);
    axr(ADDR_VALID, d, r);
    chk(d, 32'h0000_0001);
    axr(8'h0c, d, r);
    chk({d[29:0], r}, 32'(RESP_SLVERR));
    axw(8'h0c, 32'h0000_00ff, r);
    chk(32'(r), 32'(RESP_SLVERR));
    $display("Test registers done");
    for (int m = 0; m < 3; m++) begin
      seed = lfsr(seed);
      v = (m == 0) ? 6'h01 : (m == 1) ? 6'h3f : (seed[5:0] | 6'h01);
      rst();
      chk(32'(mem_sel), 32'(MEM_A));
      cfg(8'h00, v);
      e = MEM_A;
      for (k = 0; k < 7; k++) begin
        press();
        e = nxt(e, v, 1'b0);
        chk(32'(mem_sel), 32'(e));
      end
    end
    $display("Test momentary cycling done");
    rst();
    cfg(8'h02, 6'h3f);
    press();
    press();
    press();
    chk(32'(mem_sel), 32'h0000_0004);
    sw(2'h2);
    chk(32'(mem_sel), 32'(MEM_D));
    axr(ADDR_STATUS, d, r);
    chk(d, {22'h0, 1'b0, 2'b10, MEM_D, 1'b0, MEM_D});
    k = nfade;
    press();
    chk(32'(nfade), 32'(k));
    chk(32'(mem_sel), 32'(MEM_D));
    sw(2'h0);
    chk(32'(mem_sel), 32'h0000_0004);
    $display("Test momentary jump done");
    rst();
    seed = lfsr(seed);
    v = seed[5:0] | 6'h01;
    cfg(8'h0d, v);
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      sw(seed[1:0]);
      chk(32'(mem_sel), 32'(smap(seed[1:0], v)));
    end
    $display("Test static done");
    rst();
    cfg(8'h53, 6'h3d);
    sw(2'h1);
    chk(32'(mem_sel), 32'(MEM_A));
    sw(2'h2);
    chk(32'(mem_sel), 32'(MEM_D));
    k = nfade;
    sw(2'h3);
    sw(2'h2);
    chk(32'(nfade), 32'(k));
    closed <= 2'h0;
    for (k = 0; k < 400 && fade_active !== 1'b1; k++) @(posedge aclk);
    tmo(k, 400);
    chk(32'(k >= 20 && k < 80), 32'h0000_0001);
    for (k = 0; k < 2000 && indicator_play !== 1'b1; k++) begin
      @(posedge aclk);
    end
    tmo(k, 2000);
    chk(32'(mem_sel), 32'(MEM_D));
    sett();
    chk(32'(mem_sel), 32'(MEM_A));
    $display("Test static jump done");
    tally_and_finish();
  end
endmodule
